// [core/fsr_regs.sv]
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fsr_regs import fsr_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire fsr_axi_req_type axi_req,
	output fsr_axi_rsp_type axi_rsp,
	input wire fsr_mode_type mode,
	input wire logic step_out,
	input wire logic dma_req,
	input wire logic controller_irq,
	input wire logic write_gate_out,
	input wire logic write_data,
	input wire logic read_data_n,
	input wire logic second_drive_present_n,
	output logic [3:0] motor_out_n,
	output logic [3:0] drive_select_n,
	output logic soft_reset,
	output logic dma_req_pin,
	output logic dma_req_oe,
	output logic irq_pin,
	output logic irq_pin_oe,
	output logic dma_in_en
);
	fsr_regs_st_type st;
	fsr_regs_st_type next_st;
	fsr_acc_type acc;
	logic [7:0] acc_rdata;
	logic [1:0] pin_sync;
	logic read_data_s;
	logic second_drive_present_n_s;
	logic [3:0] sel;
	logic step_rise;
	logic wg_rise;
	logic rd_inact;
	logic wd_inact;
	logic dir_read;
	logic pin_en;

	// Gated one-hot drive select, active high
	function automatic logic [3:0] fsr_sel_decode(input logic [7:0] drive_output_control);
		fsr_sel_decode = (4'h1 << drive_output_control[1:0]) & drive_output_control[7:4];
	endfunction : fsr_sel_decode

	fsr_axil u_bus (
		.clk_sys(clk_sys),
		.rst(rst),
		.axi_req(axi_req),
		.axi_rsp(axi_rsp),
		.acc(acc),
		.acc_rdata(acc_rdata)
	);

	fsr_sync u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in({read_data_n, second_drive_present_n}),
		.pin_sync(pin_sync)
	);

	assign read_data_s = pin_sync[1];
	assign second_drive_present_n_s = pin_sync[0];
	assign sel = fsr_sel_decode(st.drive_output_control);
	assign step_rise = step_out && !st.step_prev;
	assign wg_rise = write_gate_out && !st.wg_prev;
	// Read data pin is active low, so its inactive edge is the rising one
	assign rd_inact = read_data_s && !st.rd_prev;
	assign wd_inact = !write_data && st.wd_prev;
	assign dir_read = acc.rd && (acc.rd_idx == `FSR_IDX_DIR);

	always_comb begin
		next_st = st;
		next_st.step_prev = step_out;
		next_st.wg_prev = write_gate_out;
		next_st.rd_prev = read_data_s;
		next_st.wd_prev = write_data;
		// Clear first, so that an edge in the same cycle wins
		if (dir_read || soft_reset) begin
			next_st.step_ff = 1'b0;
		end
		if (dir_read) begin
			next_st.wg_ff = 1'b0;
			next_st.rd_ff = 1'b0;
			next_st.wd_ff = 1'b0;
		end
		if (step_rise) begin
			next_st.step_ff = 1'b1;
		end
		if (wg_rise) begin
			next_st.wg_ff = 1'b1;
		end
		if (rd_inact) begin
			next_st.rd_ff = 1'b1;
			next_st.rd_tog = !st.rd_tog;
		end
		if (wd_inact) begin
			next_st.wd_ff = 1'b1;
			next_st.wd_tog = !st.wd_tog;
		end
		// Not touched by soft reset; only the hard reset clears these
		if (acc.wr && (acc.wr_idx == `FSR_IDX_DOR)) begin
			next_st.drive_output_control = acc.wdata;
		end
		if (acc.wr && (acc.wr_idx == `FSR_IDX_TDR)) begin
			next_st.tape = acc.wdata[1:0];
		end
		// Stretch keeps a quick 0-then-1 pair long enough for the core
		if (!st.drive_output_control[`FSR_DOR_NRST]) begin
			next_st.srst_cnt = 2'(`FSR_SRST_CYC);
		end else if (st.srst_cnt != 2'h0) begin
			next_st.srst_cnt = st.srst_cnt - 2'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.drive_output_control <= `FSR_DOR_RST;
			st.tape <= `FSR_TDR_RST;
			// Read data idles high, so no inactive edge is seen after reset
			st.rd_prev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Read data, registered by the bus slave
	always_comb begin
		acc_rdata = 8'h00;
		unique case (acc.rd_idx)
			`FSR_IDX_SRA: begin
				case (mode)
					FSR_MODE_DMAG: begin
						acc_rdata = {controller_irq, dma_req, st.step_ff, 5'h00};
					end
					FSR_MODE_EXT: begin
						acc_rdata = {controller_irq, 7'h00};
					end
					default: begin
						acc_rdata = 8'h00;
					end
				endcase
			end
			`FSR_IDX_SRB: begin
				case (mode)
					FSR_MODE_EXT: begin
						acc_rdata = {`FSR_SRB_RSVD, st.drive_output_control[`FSR_DOR_SEL_LO],
							st.wd_tog, st.rd_tog, write_gate_out,
							st.drive_output_control[`FSR_DOR_MTR_LO + 1], st.drive_output_control[`FSR_DOR_MTR_LO]};
					end
					FSR_MODE_DMAG: begin
						acc_rdata = {second_drive_present_n_s, !sel[1], !sel[0], st.wd_ff,
							st.rd_ff, st.wg_ff, !sel[3], !sel[2]};
					end
					default: begin
						acc_rdata = 8'h00;
					end
				endcase
			end
			`FSR_IDX_DOR: begin
				acc_rdata = st.drive_output_control;
			end
			`FSR_IDX_TDR: begin
				acc_rdata = {6'h00, st.tape};
			end
			default: begin
				acc_rdata = 8'h00;
			end
		endcase
	end

	assign soft_reset = !st.drive_output_control[`FSR_DOR_NRST] || (st.srst_cnt != 2'h0);
	assign motor_out_n = ~st.drive_output_control[7:4];
	assign drive_select_n = ~sel;
	// Mode is a strap, so extended mode keeps pins live through every reset
	assign pin_en = (mode == FSR_MODE_EXT) || st.drive_output_control[`FSR_DOR_DMA_PIN_ENABLE];
	assign dma_req_pin = dma_req;
	assign irq_pin = controller_irq;
	assign dma_req_oe = pin_en;
	assign irq_pin_oe = pin_en;
	assign dma_in_en = pin_en;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	step_latch_a: assert property (step_rise |=> st.step_ff && !soft_reset || st.step_ff)
		else $error("step flag missed step edge");

	step_clear_a: assert property ((dir_read && !step_rise) ##1 (!step_rise) |->
		!st.step_ff)
		else $error("step flag not cleared by input register read");

	dma_bit_a: assert property ((acc.rd && acc.rd_idx == `FSR_IDX_SRA &&
		mode == FSR_MODE_DMAG) |-> acc_rdata[6] == dma_req && acc_rdata[7] == controller_irq)
		else $error("status A DMA or interrupt bit wrong");

	srb_plain_a: assert property ((acc.rd && acc.rd_idx == `FSR_IDX_SRB &&
		mode == FSR_MODE_AT) |-> acc_rdata == 8'h00)
		else $error("status B driven in plain mode");

	srb_ext_a: assert property ((acc.rd && acc.rd_idx == `FSR_IDX_SRB &&
		mode == FSR_MODE_EXT) |-> acc_rdata[7:5] == {`FSR_SRB_RSVD, st.drive_output_control[0]} &&
		acc_rdata[1:0] == st.drive_output_control[5:4])
		else $error("status B extended layout wrong");

	rd_toggle_a: assert property (rd_inact |=> st.rd_tog != $past(st.rd_tog))
		else $error("read data toggle did not flip");

	wg_latch_a: assert property (wg_rise |=> st.wg_ff)
		else $error("write gate flag missed edge");

	sel_decode_a: assert property ($onehot0(sel) &&
		(st.drive_output_control[7:4] != 4'h0 || drive_select_n == 4'hF))
		else $error("drive select decode wrong");

	srst_len_a: assert property ($rose(soft_reset) |-> soft_reset [*3])
		else $error("soft reset shorter than minimum");

	pin_en_a: assert property ((mode == FSR_MODE_EXT) |-> dma_req_oe && irq_pin_oe)
		else $error("pins disabled in extended mode");

	dma_pin_enable_gate_a: assert property ((mode != FSR_MODE_EXT && !st.drive_output_control[3]) |->
		!dma_req_oe && !irq_pin_oe && !dma_in_en)
		else $error("pins enabled with DMA enable clear");
endmodule : fsr_regs
`default_nettype wire

// [core/fsr_map.svh]
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
// Register indices; byte address is four times the index
`define FSR_IDX_SRA 10'h3F0
`define FSR_IDX_SRB 10'h3F1
`define FSR_IDX_DOR 10'h3F2
`define FSR_IDX_TDR 10'h3F3
`define FSR_IDX_DIR 10'h3F7
// Drive output register fields
`define FSR_DOR_SEL_LO 0
`define FSR_DOR_NRST 2
`define FSR_DOR_DMA_PIN_ENABLE 3
`define FSR_DOR_MTR_LO 4
// Reset values and the status B reserved bits
`define FSR_DOR_RST 8'h00
`define FSR_TDR_RST 2'h0
`define FSR_SRB_RSVD 2'h3
// Bus answers
`define FSR_RESP_OKAY 2'h0
`define FSR_RESP_SLVERR 2'h2
// Timing
`define FSR_CLK_NS 40
`define FSR_SRST_MIN_NS 100
`define FSR_SRST_CYC ((`FSR_SRST_MIN_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`endif

// [core/fsr_pkg.sv]
`include "fsr_map.svh"
package fsr_pkg;
	typedef enum logic [1:0] {
		FSR_MODE_AT = 2'h0,
		FSR_MODE_EXT = 2'h1,
		FSR_MODE_DMAG = 2'h2
	} fsr_mode_type;

	typedef struct packed {
		logic [11:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [11:0] araddr;
		logic arvalid;
		logic rready;
	} fsr_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} fsr_axi_rsp_type;

	typedef struct packed {
		logic rd;
		logic [9:0] rd_idx;
		logic wr;
		logic [9:0] wr_idx;
		logic [7:0] wdata;
	} fsr_acc_type;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic wen;
		logic [9:0] awidx;
		logic [7:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
	} fsr_bus_st_type;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} fsr_sync_st_type;

	typedef struct packed {
		logic [7:0] drive_output_control;
		logic [1:0] tape;
		logic step_ff;
		logic wg_ff;
		logic rd_ff;
		logic wd_ff;
		logic rd_tog;
		logic wd_tog;
		logic step_prev;
		logic wg_prev;
		logic rd_prev;
		logic wd_prev;
		logic [1:0] srst_cnt;
	} fsr_regs_st_type;

	function automatic logic fsr_is_mapped(input logic [9:0] idx);
		fsr_is_mapped = (idx == `FSR_IDX_SRA) || (idx == `FSR_IDX_SRB) ||
			(idx == `FSR_IDX_DOR) || (idx == `FSR_IDX_TDR) || (idx == `FSR_IDX_DIR);
	endfunction : fsr_is_mapped
endpackage : fsr_pkg

// [core/fsr_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module fsr_sync import fsr_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [1:0] pin_in,
	output logic [1:0] pin_sync
);
	fsr_sync_st_type st;
	fsr_sync_st_type next_st;

	// First stage feeds only the second stage
	always_comb begin
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			// Both pins idle high; resetting low would fake an edge at release
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign pin_sync = st.s2;
endmodule : fsr_sync
`default_nettype wire

// [core/fsr_axil.sv]
`timescale 1ns/1ns
`default_nettype none
module fsr_axil import fsr_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire fsr_axi_req_type axi_req,
	output fsr_axi_rsp_type axi_rsp,
	output fsr_acc_type acc,
	input wire logic [7:0] acc_rdata
);
	fsr_bus_st_type st;
	fsr_bus_st_type next_st;
	logic aw_take;
	logic w_take;
	logic ar_take;

	always_comb begin
		aw_take = axi_req.awvalid && !st.aw_got && !st.bvalid;
		w_take = axi_req.wvalid && !st.w_got && !st.bvalid;
		ar_take = axi_req.arvalid && !st.rvalid;
		acc.rd = ar_take;
		acc.rd_idx = axi_req.araddr[11:2];
		// Only byte lane 0 carries register data
		acc.wr = st.aw_got && st.w_got && st.wen;
		acc.wr_idx = st.awidx;
		acc.wdata = st.wdata;
		next_st = st;
		if (aw_take) begin
			next_st.aw_got = 1'b1;
			next_st.awidx = axi_req.awaddr[11:2];
		end
		if (w_take) begin
			next_st.w_got = 1'b1;
			next_st.wdata = axi_req.wdata[7:0];
			next_st.wen = axi_req.wstrb[0];
		end
		if (st.aw_got && st.w_got) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = fsr_is_mapped(st.awidx) ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
		end else if (st.bvalid && axi_req.bready) begin
			next_st.bvalid = 1'b0;
		end
		if (ar_take) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = fsr_is_mapped(acc.rd_idx) ? acc_rdata : 8'h00;
			next_st.rresp = fsr_is_mapped(acc.rd_idx) ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
		end else if (st.rvalid && axi_req.rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		axi_rsp.awready = !st.aw_got && !st.bvalid;
		axi_rsp.wready = !st.w_got && !st.bvalid;
		axi_rsp.bresp = st.bresp;
		axi_rsp.bvalid = st.bvalid;
		axi_rsp.arready = !st.rvalid;
		axi_rsp.rdata = {24'h000000, st.rdata};
		axi_rsp.rresp = st.rresp;
		axi_rsp.rvalid = st.rvalid;
	end
endmodule : fsr_axil
`default_nettype wire

// [verif/fsr_drive_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Drive and core side of the block: pin levels follow the bench one clock late,
// so every level change lands just after an edge, as on a clocked core
module fsr_drive_model (
	input wire logic clk_sys,
	input wire logic [6:0] want,
	output logic [6:0] pins
);
	always_ff @(posedge clk_sys) begin
		pins <= want;
	end
endmodule : fsr_drive_model
`default_nettype wire

// [verif/test_floppy_status_and_drive_control_regs.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fsr_map.svh"
module test_floppy_status_and_drive_control_regs import fsr_pkg::*;;
	logic clk_sys;
	logic rst;
	fsr_mode_type mode;
	fsr_axi_req_type req;
	fsr_axi_rsp_type rsp;
	// Pin bits: step, dma request, irq, write gate, write data, read data_n, drive two_n
	logic [6:0] p;
	logic [6:0] pins;
	logic [3:0] motor_out_n;
	logic [3:0] drive_select_n;
	logic soft_reset;
	logic dma_req_pin;
	logic irq_pin;
	wire [2:0] oe;
	int fail_count = 0;
	int num_checks = 0;

	fsr_drive_model far (.clk_sys(clk_sys), .want(p), .pins(pins));
	fsr_regs dut (
		.clk_sys(clk_sys), .rst(rst), .axi_req(req), .axi_rsp(rsp), .mode(mode),
		.step_out(pins[0]), .dma_req(pins[1]), .controller_irq(pins[2]),
		.write_gate_out(pins[3]), .write_data(pins[4]), .read_data_n(pins[5]),
		.second_drive_present_n(pins[6]), .motor_out_n(motor_out_n),
		.drive_select_n(drive_select_n), .soft_reset(soft_reset),
		.dma_req_pin(dma_req_pin), .dma_req_oe(oe[2]), .irq_pin(irq_pin),
		.irq_pin_oe(oe[1]), .dma_in_en(oe[0])
	);

	always #20 clk_sys = ~clk_sys;

	task automatic finish_test();
		if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// Starts one edge late so a strobe dropped by the last transfer is never re-raised
	// in the same time step
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		logic a;
		logic w;
		logic b;
		a = 1'h1;
		w = 1'h1;
		b = 1'h1;
		@(posedge clk_sys);
		req.awaddr <= {i, 2'h0};
		req.awvalid <= 1'h1;
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hF;
		req.wvalid <= 1'h1;
		req.bready <= 1'h1;
		while (b) begin
			@(posedge clk_sys);
			if (a && rsp.awready) a = 1'h0;
			if (w && rsp.wready) w = 1'h0;
			if (!a) req.awvalid <= 1'h0;
			if (!w) req.wvalid <= 1'h0;
			if (rsp.bvalid) begin
				b = 1'h0;
				req.bready <= 1'h0;
				chk(rsp.bresp, 2'h0);
			end
		end
	endtask : wr

	task automatic rd(input logic [9:0] i, input logic [7:0] e, input logic [1:0] re = 2'h0);
		logic r;
		r = 1'h1;
		@(posedge clk_sys);
		req.araddr <= {i, 2'h0};
		req.arvalid <= 1'h1;
		req.rready <= 1'h1;
		while (r) begin
			@(posedge clk_sys);
			if (rsp.rvalid) begin
				r = 1'h0;
				req.rready <= 1'h0;
				chk({rsp.rresp, rsp.rdata}, {re, 24'h0, e});
			end else if (rsp.arready) req.arvalid <= 1'h0;
		end
	endtask : rd

	// Inverts the masked pins for three cycles; sync stages need the settle time after
	task automatic pl(input logic [6:0] m);
		@(posedge clk_sys);
		p <= p ^ m;
		repeat (3) @(posedge clk_sys);
		p <= p ^ m;
		repeat (8) @(posedge clk_sys);
	endtask : pl

	// Mode is a strap, so it only changes under hard reset
	task automatic rs(input fsr_mode_type m);
		rst <= 1'h1;
		mode <= m;
		p <= 7'h60;
		repeat (8) @(posedge clk_sys);
		chk(oe, {3{m == FSR_MODE_EXT}});
		rst <= 1'h0;
	endtask : rs

	task automatic t_at();
		logic [7:0] v[4];
		v = '{8'h1C, 8'h2D, 8'h4E, 8'h8F};
		chk({motor_out_n, drive_select_n, soft_reset, oe}, {8'hFF, 1'h1, 3'h0});
		rd(`FSR_IDX_DOR, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(`FSR_IDX_DOR, v[k]);
			chk({motor_out_n, drive_select_n, oe}, {~v[k][7:4], ~(4'h1 << k), 3'h7});
		end
		wr(`FSR_IDX_DOR, 8'h07);
		chk({motor_out_n, drive_select_n, oe}, {8'hFF, 3'h0});
		rd(`FSR_IDX_SRB, 8'h00);
		wr(`FSR_IDX_TDR, 8'hFF);
		rd(`FSR_IDX_TDR, 8'h03);
		rd(10'h3F5, 8'h00, `FSR_RESP_SLVERR);
	endtask : t_at

	task automatic t_srst();
		int n;
		wr(`FSR_IDX_DOR, 8'h18);
		chk({soft_reset, motor_out_n}, {1'h1, 4'hE});
		wr(`FSR_IDX_DOR, 8'h1C);
		chk(soft_reset, 1'h1);
		n = 0;
		while (soft_reset !== 1'h0 && n < 8) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n < 8, 1'h1);
		rd(`FSR_IDX_DOR, 8'h1C);
		rd(`FSR_IDX_TDR, 8'h03);
	endtask : t_srst

	task automatic t_ext();
		rs(FSR_MODE_EXT);
		rd(`FSR_IDX_DOR, 8'h00);
		wr(`FSR_IDX_DOR, 8'h31);
		chk(oe, 3'h7);
		rd(`FSR_IDX_SRB, 8'hE3);
		p <= 7'h6C;
		repeat (6) @(posedge clk_sys);
		rd(`FSR_IDX_SRB, 8'hE7);
		rd(`FSR_IDX_SRA, 8'h80);
		pl(7'h30);
		rd(`FSR_IDX_SRB, 8'hFF);
		pl(7'h10);
		rd(`FSR_IDX_SRB, 8'hEF);
	endtask : t_ext

	task automatic t_dmag();
		rs(FSR_MODE_DMAG);
		rd(`FSR_IDX_SRB, 8'hE3);
		wr(`FSR_IDX_DOR, 8'h2D);
		p <= 7'h28;
		pl(7'h30);
		rd(`FSR_IDX_SRB, 8'h3F);
		rd(`FSR_IDX_DIR, 8'h00);
		rd(`FSR_IDX_SRB, 8'h23);
		p <= 7'h2E;
		pl(7'h01);
		chk({dma_req_pin, irq_pin, oe}, 5'h1F);
		rd(`FSR_IDX_SRA, 8'hE0);
		rd(`FSR_IDX_DIR, 8'h00);
		rd(`FSR_IDX_SRA, 8'hC0);
		pl(7'h01);
		wr(`FSR_IDX_DOR, 8'h29);
		rd(`FSR_IDX_SRA, 8'hC0);
	endtask : t_dmag

	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		finish_test();
	end

	initial begin
		clk_sys = 1'h0;
		rst = 1'h1;
		mode = FSR_MODE_AT;
		req = '0;
		p = 7'h60;
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
		t_at();
		t_srst();
		t_ext();
		t_dmag();
		finish_test();
	end
endmodule : test_floppy_status_and_drive_control_regs
`default_nettype wire
